// ### cgt_device.sv
// Carrier generator timer: count clock, carrier toggling, gate pair and output pin.
`timescale 1ns/1ps
`default_nettype none
`include "cgt_defines.svh"
module cgt_device
  import cgt_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  cgt_link_if.dev link,
  output logic counting_o,
  output logic carrier_clock_o
);
  logic [`CGT_PRESC_W-1:0] presc_ff;
  logic [`CGT_PRESC_W-1:0] presc_mask;
  logic [`CGT_CMP_W-1:0] cnt_ff;
  logic [`CGT_CMP_W-1:0] high_act_ff;
  logic [`CGT_CMP_W-1:0] high_pend_ff;
  logic [`CGT_CMP_W-1:0] cmp_sel;
  logic [`CGT_AGE_W-1:0] pend_age_ff;
  cgt_phase_e phase_ff;
  logic run_ff, started_ff, tick, match;
  logic carrier_ff, irq_ff, pend_ff;
  logic gbuf_ff, gact_ff;
  logic xreq_ff, xs0_ff, xs1_ff, xs2_ff, xfer;
  logic out_en_ff, pin_ff;

  // ---------------------------------------------------------------
  // Count clock
  // ---------------------------------------------------------------
  // One mask bit per prescaler bit, so a select of s ticks once per 2^s clocks.
  genvar gi;
  generate
    for (gi = 0; gi < `CGT_PRESC_W; gi = gi + 1) begin : g_mask
      assign presc_mask[gi] = ({1'b0, link.count_clock_select} > (`CGT_SEL_W+1)'(gi));
    end
  endgenerate

  assign tick = run_ff && ((presc_ff & presc_mask) == presc_mask);

  // Prescaler restarts with the run bit so the first count clock has a fixed phase.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_ff <= 1'b0;
      presc_ff <= `CGT_CNT_CLEAR;
    end else begin
      run_ff <= link.carrier_timer_run;
      if (!run_ff) begin
        presc_ff <= `CGT_CNT_CLEAR;
      end else begin
        presc_ff <= presc_ff + `CGT_CNT_ONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Counter and compare alternation
  // ---------------------------------------------------------------
  assign cmp_sel = (phase_ff == CGT_PH_HIGH) ? high_act_ff : link.low_width_compare;
  assign match = tick && started_ff && (cnt_ff == cmp_sel);

  // The first count clock after start is swallowed, then the counter runs 0..N and 0..M.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      started_ff <= 1'b0;
      cnt_ff <= `CGT_CNT_CLEAR;
      phase_ff <= CGT_PH_LOW;
      carrier_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= 1'b0;
      if (!run_ff) begin
        started_ff <= 1'b0;
        cnt_ff <= `CGT_CNT_CLEAR;
        phase_ff <= CGT_PH_LOW;
        carrier_ff <= 1'b0;
      end else if (tick) begin
        started_ff <= 1'b1;
        if (match) begin
          irq_ff <= 1'b1;
          cnt_ff <= `CGT_CNT_CLEAR;
          carrier_ff <= !carrier_ff;
          phase_ff <= (phase_ff == CGT_PH_LOW) ? CGT_PH_HIGH : CGT_PH_LOW;
        end else if (started_ff) begin
          cnt_ff <= cnt_ff + `CGT_CNT_ONE;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // High width reload
  // ---------------------------------------------------------------
  // A running write waits for the old high match; a write younger than three count
  // clocks misses that match and waits for the next one.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      high_act_ff <= `CGT_RST_CMP;
      high_pend_ff <= `CGT_RST_CMP;
      pend_ff <= 1'b0;
      pend_age_ff <= 2'h0;
    end else begin
      if (link.high_wr) begin
        high_pend_ff <= link.high_width_compare;
        pend_ff <= run_ff;
        pend_age_ff <= 2'h0;
        if (!run_ff) begin
          high_act_ff <= link.high_width_compare;
        end
      end else if (pend_ff) begin
        if (match && (phase_ff == CGT_PH_HIGH) && (pend_age_ff == `CGT_HIGH_SETTLE_TICKS)) begin
          high_act_ff <= high_pend_ff;
          pend_ff <= 1'b0;
        end else if (tick && (pend_age_ff != `CGT_HIGH_SETTLE_TICKS)) begin
          pend_age_ff <= pend_age_ff + 2'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Gate master and slave pair
  // ---------------------------------------------------------------
  // The interrupt is held until a count clock takes it, since it lasts one fast clock.
  // One that arrives while stopped is dropped, so a restart never replays a stale transfer.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xreq_ff <= 1'b0;
      xs0_ff <= 1'b0;
      xs1_ff <= 1'b0;
      xs2_ff <= 1'b0;
    end else begin
      if (!run_ff) begin
        xreq_ff <= 1'b0;
      end else if (link.companion_period_irq) begin
        xreq_ff <= 1'b1;
      end else if (tick) begin
        xreq_ff <= 1'b0;
      end
      if (!run_ff) begin
        xs0_ff <= 1'b0;
        xs1_ff <= 1'b0;
        xs2_ff <= 1'b0;
      end else if (tick) begin
        xs0_ff <= xreq_ff && !xs0_ff;
        xs1_ff <= xs0_ff;
        xs2_ff <= xs1_ff;
      end
    end
  end

  assign xfer = tick && xs1_ff && !xs2_ff;

  // Software owns the buffer; only the transfer pulse moves it into the active bit.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gbuf_ff <= 1'b0;
      gact_ff <= 1'b0;
    end else begin
      if (link.gate_wr) begin
        gbuf_ff <= link.gate_wdata;
      end
      if (xfer) begin
        gact_ff <= gbuf_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output pin
  // ---------------------------------------------------------------
  // The enable changes only with the carrier low or on stop, so gating never cuts a high pulse short.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_en_ff <= 1'b0;
      pin_ff <= 1'b0;
    end else begin
      if (!run_ff) begin
        out_en_ff <= 1'b0;
      end else if (gact_ff && match && !carrier_ff) begin
        out_en_ff <= 1'b1;
      end else if (!gact_ff && !carrier_ff) begin
        out_en_ff <= 1'b0;
      end
      if (!link.remote_output_enable) begin
        pin_ff <= gbuf_ff;
      end else begin
        pin_ff <= carrier_ff && out_en_ff && run_ff;
      end
    end
  end

  assign link.carrier_output_pin = pin_ff;
  assign link.compare_match_irq = irq_ff;
  assign link.carrier_gate_active = gact_ff;
  assign link.carrier_gate_buffer = gbuf_ff;
  assign link.synced_transfer_pulse = xs0_ff;
  assign counting_o = started_ff;
  assign carrier_clock_o = carrier_ff;
endmodule
`default_nettype wire

// ### cgt_defines.svh
// Constants of the carrier generator timer and its companion end.
`ifndef CGT_DEFINES_SVH
`define CGT_DEFINES_SVH
`define CGT_CMP_W 8
`define CGT_SEL_W 3
`define CGT_PRESC_W 8
`define CGT_CMP_MIN 8'h01
`define CGT_CNT_CLEAR 8'h00
`define CGT_CNT_ONE 8'h01
`define CGT_HIGH_SETTLE_TICKS 2'h3
`define CGT_AGE_W 2
`define CGT_RATIO_SHIFT 4'h3
`define CGT_RST_CMP 8'h01
`define CGT_RST_SEL 3'h0
`endif

// ### cgt_pkg.sv
// Types shared by the carrier generator timer and its companion end.
package cgt_pkg;
  typedef enum logic [1:0] {
    CGT_PH_LOW = 2'b01,
    CGT_PH_HIGH = 2'b10
  } cgt_phase_e;
  typedef enum logic [2:0] {
    CGT_HS_IDLE = 3'b001,
    CGT_HS_ARM = 3'b010,
    CGT_HS_RUN = 3'b100
  } cgt_host_state_e;
endpackage

// ### cgt_link_if.sv
// Link between the carrier generator timer and its controlling end.
`timescale 1ns/1ps
`default_nettype none
`include "cgt_defines.svh"
interface cgt_link_if;
  logic carrier_timer_run;
  logic remote_output_enable;
  logic [`CGT_SEL_W-1:0] count_clock_select;
  logic gate_wr;
  logic gate_wdata;
  logic [`CGT_CMP_W-1:0] low_width_compare;
  logic [`CGT_CMP_W-1:0] high_width_compare;
  logic high_wr;
  logic companion_period_irq;
  logic carrier_output_pin;
  logic compare_match_irq;
  logic carrier_gate_active;
  logic carrier_gate_buffer;
  logic synced_transfer_pulse;
  modport dev (
    input carrier_timer_run, remote_output_enable, count_clock_select, gate_wr, gate_wdata,
    input low_width_compare, high_width_compare, high_wr, companion_period_irq,
    output carrier_output_pin, compare_match_irq, carrier_gate_active, carrier_gate_buffer,
    output synced_transfer_pulse
  );
  modport host (
    output carrier_timer_run, remote_output_enable, count_clock_select, gate_wr, gate_wdata,
    output low_width_compare, high_width_compare, high_wr, companion_period_irq,
    input carrier_output_pin, compare_match_irq, carrier_gate_active, carrier_gate_buffer,
    input synced_transfer_pulse
  );
endinterface
`default_nettype wire

// ### cgt_host.sv
// Controlling end: register programming sequence and companion period timer.
`timescale 1ns/1ps
`default_nettype none
`include "cgt_defines.svh"
module cgt_host
  import cgt_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  cgt_link_if.host link,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic remote_i,
  input wire logic gate_wr_i,
  input wire logic gate_i,
  input wire logic low_wr_i,
  input wire logic high_wr_i,
  input wire logic [7:0] value_i,
  input wire logic [2:0] clk_sel_i,
  input wire logic companion_timer_run_i,
  input wire logic [2:0] companion_sel_i,
  input wire logic [7:0] companion_period_i,
  output logic refused_o,
  output logic running_o,
  output logic pin_o,
  output logic match_o,
  output logic gate_active_o,
  output logic gate_buffer_o
);
  cgt_host_state_e state_ff;
  logic run_ff, rmt_ff, hwr_ff, gwr_ff, gdat_ff, refused_ff, comp_run_ff, irq_ff;
  logic [7:0] low_ff, high_ff, comp_cnt_ff, comp_per_ff, comp_presc_ff;
  logic [2:0] sel_ff, comp_sel_ff;
  logic bad_value, low_bad, high_bad, start_ok, comp_ok, comp_tick;

  // Zero compare values, low writes while counting and companion timers started too fast for the count clock are refused.
  assign bad_value = (value_i < `CGT_CMP_MIN);
  assign low_bad = bad_value || (state_ff != CGT_HS_IDLE);
  assign high_bad = bad_value;
  assign start_ok = (state_ff == CGT_HS_IDLE) && !stop_i;
  assign comp_ok = ({1'b0, companion_sel_i} >= ({1'b0, sel_ff} + `CGT_RATIO_SHIFT));

  // ---------------------------------------------------------------
  // Start and stop sequence
  // ---------------------------------------------------------------
  // Remote enable and the high width rewrite go out one cycle ahead of the run bit.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= CGT_HS_IDLE;
      run_ff <= 1'b0;
      rmt_ff <= 1'b0;
      sel_ff <= `CGT_RST_SEL;
    end else begin
      case (state_ff)
        CGT_HS_IDLE: begin
          if (start_i && !stop_i) begin
            rmt_ff <= remote_i;
            sel_ff <= clk_sel_i;
            state_ff <= CGT_HS_ARM;
          end
        end
        CGT_HS_ARM: begin
          run_ff <= 1'b1;
          state_ff <= CGT_HS_RUN;
        end
        CGT_HS_RUN: begin
          if (stop_i) begin
            run_ff <= 1'b0;
            state_ff <= CGT_HS_IDLE;
          end
        end
        default: state_ff <= CGT_HS_IDLE;
      endcase
    end
  end

  // Compare values; every start resends the held high width value.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_ff <= `CGT_RST_CMP;
      high_ff <= `CGT_RST_CMP;
      hwr_ff <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      hwr_ff <= (high_wr_i && !high_bad) || (start_i && start_ok);
      refused_ff <= (low_wr_i && low_bad) || (high_wr_i && high_bad) ||
                    (companion_timer_run_i && !comp_run_ff && !comp_ok);
      if (low_wr_i && !low_bad) begin
        low_ff <= value_i;
      end
      if (high_wr_i && !high_bad) begin
        high_ff <= value_i;
      end
    end
  end

  // Gate buffer write strobe.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gwr_ff <= 1'b0;
      gdat_ff <= 1'b0;
    end else begin
      gwr_ff <= gate_wr_i;
      if (gate_wr_i) begin
        gdat_ff <= gate_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Companion period timer
  // ---------------------------------------------------------------
  assign comp_tick = ((comp_presc_ff & ((8'h01 << comp_sel_ff) - 8'h01)) == ((8'h01 << comp_sel_ff) - 8'h01));

  // One period interrupt each time the count reaches the period value.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comp_run_ff <= 1'b0;
      comp_sel_ff <= `CGT_RST_SEL;
      comp_per_ff <= `CGT_RST_CMP;
      comp_presc_ff <= `CGT_CNT_CLEAR;
      comp_cnt_ff <= `CGT_CNT_CLEAR;
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= 1'b0;
      if (!companion_timer_run_i) begin
        comp_run_ff <= 1'b0;
      end else if (!comp_run_ff && comp_ok) begin
        comp_run_ff <= 1'b1;
        comp_sel_ff <= companion_sel_i;
        comp_per_ff <= companion_period_i;
      end
      if (!comp_run_ff) begin
        comp_presc_ff <= `CGT_CNT_CLEAR;
        comp_cnt_ff <= `CGT_CNT_CLEAR;
      end else begin
        comp_presc_ff <= comp_presc_ff + `CGT_CNT_ONE;
        if (comp_tick) begin
          if (comp_cnt_ff >= comp_per_ff) begin
            comp_cnt_ff <= `CGT_CNT_CLEAR;
            irq_ff <= 1'b1;
          end else begin
            comp_cnt_ff <= comp_cnt_ff + `CGT_CNT_ONE;
          end
        end
      end
    end
  end

  assign link.carrier_timer_run = run_ff;
  assign link.remote_output_enable = rmt_ff;
  assign link.count_clock_select = sel_ff;
  assign link.gate_wr = gwr_ff;
  assign link.gate_wdata = gdat_ff;
  assign link.low_width_compare = low_ff;
  assign link.high_width_compare = high_ff;
  assign link.high_wr = hwr_ff;
  assign link.companion_period_irq = irq_ff;
  assign refused_o = refused_ff;
  assign running_o = run_ff;
  assign pin_o = link.carrier_output_pin;
  assign match_o = link.compare_match_irq;
  assign gate_active_o = link.carrier_gate_active;
  assign gate_buffer_o = link.carrier_gate_buffer;
endmodule
`default_nettype wire

// ### cgt_link_monitor.sv
// Concurrent checks on the link between the carrier timer and its controlling end.
`timescale 1ns/1ps
`default_nettype none
module cgt_link_monitor (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic carrier_timer_run,
  input wire logic remote_output_enable,
  input wire logic [2:0] count_clock_select,
  input wire logic [7:0] low_width_compare,
  input wire logic companion_period_irq,
  input wire logic carrier_output_pin,
  input wire logic compare_match_irq,
  input wire logic carrier_gate_active,
  input wire logic carrier_gate_buffer,
  input wire logic synced_transfer_pulse
);
  // ----------------------------------------
  // Helper state and assertions
  // ----------------------------------------
  logic [8:0] gap_ff;
  logic ph_ff;
  logic seen_ff;
  // Timing checks hold only with one tick per clock, so the bench's half-rate run meets only the ungated start and stop checks.
  wire run_fast = carrier_timer_run && count_clock_select == 3'h0;

  // Cycles since the last match, and whether that match opened the high phase.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_ff <= 9'h000;
      ph_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else if (!carrier_timer_run) begin
      ph_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else if (compare_match_irq) begin
      gap_ff <= 9'h001;
      ph_ff <= !ph_ff;
      seen_ff <= 1'b1;
    end else begin
      gap_ff <= gap_ff + 9'h001;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_no_match3;
    !compare_match_irq [*3];
  endsequence

  a_quiet_start: assert property ($rose(carrier_timer_run) |-> s_no_match3)
    else $error("match right after start");
  a_low_gap: assert property (compare_match_irq && seen_ff && !ph_ff && run_fast |->
    gap_ff == {1'b0, low_width_compare} + 9'h001)
    else $error("low phase length wrong");
  a_irq_single: assert property (compare_match_irq && run_fast |=> !compare_match_irq)
    else $error("match pulse too long");
  a_stop_quiet: assert property (!carrier_timer_run && !$past(carrier_timer_run) &&
    !$past(carrier_timer_run, 2) |-> !compare_match_irq)
    else $error("match while stopped");
  a_stop_pin: assert property ($fell(carrier_timer_run) && remote_output_enable |-> ##3 !carrier_output_pin)
    else $error("pin not cleared by stop");
  a_remote_off: assert property ($rose(carrier_gate_buffer) && !remote_output_enable |->
    ##[0:1] carrier_output_pin)
    else $error("pin not following buffer");
  a_pin_rise: assert property ($rose(carrier_output_pin) && remote_output_enable && run_fast |->
    compare_match_irq || $past(compare_match_irq))
    else $error("pin rose off a carrier edge");
  a_pin_fall: assert property ($fell(carrier_output_pin) && remote_output_enable && run_fast &&
    $past(carrier_timer_run, 2) |-> compare_match_irq || $past(compare_match_irq))
    else $error("pin fell inside high width");
  a_gate_copy: assert property ($changed(carrier_gate_active) && run_fast |->
    $past(synced_transfer_pulse) || $past(synced_transfer_pulse, 2) || $past(synced_transfer_pulse, 3))
    else $error("gate copied without transfer pulse");
  a_sync_rise: assert property ($rose(synced_transfer_pulse) && run_fast |->
    $past(companion_period_irq) || $past(companion_period_irq, 2) || $past(companion_period_irq, 3))
    else $error("transfer pulse without period irq");
  a_sync_short: assert property ($rose(synced_transfer_pulse) && run_fast |=> !synced_transfer_pulse)
    else $error("transfer pulse too long");
endmodule
`default_nettype wire

// ### cgt_tb_top.sv
// Self-checking bench for the carrier timer and its controlling end.
`timescale 1ns/1ps
`default_nettype none
module cgt_tb_top;
  // ----------------------------------------
  // Stimulus, checks and scenarios
  // ----------------------------------------
  typedef struct {logic [7:0] n; logic [7:0] m; logic [15:0] lo; logic [15:0] hi;} cgt_row_s;
  cgt_row_s rows [6] = '{'{8'h01, 8'h01, 16'h0002, 16'h0002}, '{8'h03, 8'h03, 16'h0004, 16'h0004},
    '{8'h05, 8'h02, 16'h0006, 16'h0003}, '{8'h02, 8'h06, 16'h0003, 16'h0007},
    '{8'h01, 8'hFF, 16'h0002, 16'h0100}, '{8'hFF, 8'h01, 16'h0100, 16'h0002}};
  logic mclk_i, resetn_i, start, stop, remote, gate_wr, gate_d, low_wr, high_wr, comp_run;
  logic [7:0] value, comp_period;
  logic [2:0] clk_sel, comp_sel;
  logic refused, running, pin, match, gate_act, gate_buf, counting, carrier;
  logic refused_seen;
  int miscompares, comparisons, lo, hi;
  cgt_link_if link ();
  cgt_host i_cgt_host (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(link), .start_i(start), .stop_i(stop),
    .remote_i(remote), .gate_wr_i(gate_wr), .gate_i(gate_d), .low_wr_i(low_wr), .high_wr_i(high_wr),
    .value_i(value), .clk_sel_i(clk_sel), .companion_timer_run_i(comp_run), .companion_sel_i(comp_sel),
    .companion_period_i(comp_period), .refused_o(refused), .running_o(running), .pin_o(pin),
    .match_o(match), .gate_active_o(gate_act), .gate_buffer_o(gate_buf));
  cgt_device i_cgt_device (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(link), .counting_o(counting),
    .carrier_clock_o(carrier));
  cgt_link_monitor i_cgt_link_monitor (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .carrier_timer_run(link.carrier_timer_run), .remote_output_enable(link.remote_output_enable),
    .count_clock_select(link.count_clock_select), .low_width_compare(link.low_width_compare),
    .companion_period_irq(link.companion_period_irq), .carrier_output_pin(link.carrier_output_pin),
    .compare_match_irq(link.compare_match_irq), .carrier_gate_active(link.carrier_gate_active),
    .carrier_gate_buffer(link.carrier_gate_buffer), .synced_transfer_pulse(link.synced_transfer_pulse));

  // Free-running 100 MHz clock.
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic wr_cmp(input logic is_hi, input logic [7:0] v);
    value = v;
    high_wr = is_hi;
    low_wr = !is_hi;
    tick(1);
    high_wr = 1'b0;
    low_wr = 1'b0;
    // The refusal flag stands for one cycle, so it is taken before the strobes may rise again.
    refused_seen = refused;
    tick(1);
  endtask
  task automatic set_gate(input logic v);
    gate_d = v;
    gate_wr = 1'b1;
    tick(1);
    gate_wr = 1'b0;
    tick(3);
  endtask
  // Remote enable goes with the start request, so it is never set after counting begins.
  task automatic go(input logic rmt);
    remote = rmt;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(3);
  endtask
  task automatic halt();
    stop = 1'b1;
    tick(1);
    stop = 1'b0;
    tick(4);
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? carrier : k == 1 ? gate_act : k == 2 ? pin : match;
  endfunction
  // A bounded wait; running out of patience ends the run as a failure.
  task automatic wait_for(input int k, input logic v);
    int n;
    n = 0;
    while (pick(k) !== v) begin
      n++;
      if (n > 3000) begin
        miscompares++;
        tally_and_finish();
      end
      tick(1);
    end
  endtask
  task automatic span(input int k, input logic v, output int n);
    n = 0;
    while (pick(k) === v && n < 600) begin
      n++;
      tick(1);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    {resetn_i, start, stop, remote, gate_wr, gate_d, low_wr, high_wr, comp_run} = 9'h000;
    {value, comp_period, clk_sel, comp_sel} = 22'h000000;
    miscompares = 0;
    comparisons = 0;
    tick(8);
    resetn_i = 1'b1;
    tick(1);
    check("reset", {10'h000, pin, running, gate_act, match, carrier, counting}, 16'h0000);
    foreach (rows[i]) begin
      wr_cmp(1'b0, rows[i].n);
      wr_cmp(1'b1, rows[i].m);
      go(1'b1);
      check("running", {14'h0000, counting, running}, 16'h0003);
      wait_for(0, 1'b1);
      wait_for(0, 1'b0);
      span(0, 1'b0, lo);
      span(0, 1'b1, hi);
      check("low width", 16'(lo), rows[i].lo);
      check("high width", 16'(hi), rows[i].hi);
      wait_for(3, 1'b1);
      tick(1);
      check("match pulse", 16'(match), 16'h0000);
      halt();
      check("stopped", {14'h0000, carrier, pin}, 16'h0000);
    end
    // Count clock of half the system clock: every width doubles.
    clk_sel = 3'h1;
    wr_cmp(1'b0, 8'h02);
    wr_cmp(1'b1, 8'h01);
    go(1'b1);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    span(0, 1'b0, lo);
    span(0, 1'b1, hi);
    check("slow low width", 16'(lo), 16'h0006);
    check("slow high width", 16'(hi), 16'h0004);
    halt();
    clk_sel = 3'h0;
    // A zero compare value and a too-fast companion are both turned away.
    wr_cmp(1'b0, 8'h00);
    check("zero refused", 16'(refused_seen), 16'h0001);
    comp_sel = 3'h2;
    comp_run = 1'b1;
    tick(1);
    check("ratio refused", 16'(refused), 16'h0001);
    comp_run = 1'b0;
    tick(2);
    // Remote output off: the pin shows the buffer level, carrier or not.
    wr_cmp(1'b0, 8'h03);
    wr_cmp(1'b1, 8'h03);
    go(1'b0);
    set_gate(1'b1);
    check("static high", {13'h0000, gate_act, gate_buf, pin}, 16'h0003);
    set_gate(1'b0);
    check("static low", 16'(pin), 16'h0000);
    halt();
    // Gate transfer through the companion period, then gating off.
    set_gate(1'b1);
    go(1'b1);
    comp_sel = 3'h3;
    comp_period = 8'h04;
    comp_run = 1'b1;
    wait_for(1, 1'b1);
    wait_for(2, 1'b1);
    check("gated carrier", 16'(carrier), 16'h0001);
    set_gate(1'b0);
    wait_for(1, 1'b0);
    tick(8);
    span(2, 1'b0, lo);
    check("pin held low", 16'(lo), 16'h0258);
    // High width rewritten while counting takes effect at a later high match.
    wr_cmp(1'b1, 8'h06);
    tick(30);
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    span(0, 1'b1, hi);
    check("new high width", 16'(hi), 16'h0007);
    wr_cmp(1'b0, 8'h05);
    check("low write refused", 16'(refused_seen), 16'h0001);
    halt();
    comp_run = 1'b0;
    // Second reset in mid-run clears everything again.
    go(1'b1);
    resetn_i = 1'b0;
    tick(2);
    resetn_i = 1'b1;
    tick(1);
    check("second reset", {12'h000, pin, running, carrier, counting}, 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
